// ### test/engine_model.sv
/*
 * stand-in for the erase, self-test and checksum engines.
 * assumes start pulses last one cycle; answers four cycles later.
 */
`timescale 1ns/10ps
module engine_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire debug_service_pkg::op_starts_s op_starts,
	input wire logic make_fail,
	output debug_service_pkg::op_events_s op_events
);
	logic [2:0] wait_r;

	// ****************************************
	// delayed completion
	// ****************************************
	// fail also raises bus error, so one run covers both flags
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wait_r <= 3'h0;
			op_events <= '0;
		end else begin
			op_events <= '0;
			if (op_starts != '0) begin
				wait_r <= 3'h4;
			end else if (wait_r != 3'h0) begin
				wait_r <= wait_r - 3'h1;
				if (wait_r == 3'h1) begin
					op_events <= {1'b1, make_fail, make_fail};
				end
			end
		end
	end
endmodule : engine_model

// ### test/tb.sv
/*
 * self-checking bench of the debug service front end.
 * assumes one AHB-Lite master (this bench) and the engine stand-in.
 */
`timescale 1ns/10ps
module tb;
	logic clk_sys = 1'b0;
	logic rstn = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	debug_service_pkg::op_events_s op_events;
	debug_service_pkg::op_starts_s op_starts;
	logic write_guard_on = 1'b0;
	logic device_locked = 1'b0;
	logic probe_at_coldstart = 1'b0;
	logic probe_detected = 1'b0;
	logic swclk_reassigned = 1'b0;
	logic make_fail = 1'b0;
	logic cpu_hold;
	logic [4:0] event_flags;
	logic [4:0] state_flags;
	logic clr = 1'b0;
	logic [2:0] seen_r = 3'h0;
	logic [31:0] rd;
	int miscompares = 0;
	int check_count = 0;

	always #12.5 clk_sys = ~clk_sys;
	// start pulses are one cycle; keep them sticky for later judging
	always @(posedge clk_sys) seen_r <= clr ? 3'h0 : (seen_r | op_starts);

	debug_service_unit debug_service_unit_inst (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .op_events(op_events),
		.write_guard_on(write_guard_on), .device_locked(device_locked), .probe_at_coldstart(probe_at_coldstart),
		.probe_detected(probe_detected), .swclk_reassigned(swclk_reassigned), .op_starts(op_starts),
		.cpu_hold(cpu_hold), .event_flags(event_flags), .state_flags(state_flags));
	engine_model engine_model_inst (.clk_sys(clk_sys), .rstn(rstn), .op_starts(op_starts),
		.make_fail(make_fail), .op_events(op_events));

	// ****************************************
	// helpers
	// ****************************************
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	task automatic clr_seen();
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
	endtask : clr_seen

	task automatic bus(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= sz;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 80);
		rd = hrdata;
		chk("bus wait", 32'h0, {31'h0, n >= 80});
		chk("bus resp", 32'h0, {31'h0, hresp});
	endtask : bus

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		bus(1'b0, 32'h8, 3'h0, 32'h0);
		chk("status b", 32'h10, rd & 32'hff);
		bus(1'b0, 32'h4, 3'h2, 32'h0);
		chk("status a", 32'h0, rd);
		bus(1'b0, 32'h100, 3'h2, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask : t_reset

	task automatic t_commands();
		for (int b = 2; b < 5; b++) begin
			clr_seen();
			make_fail <= (b == 2);
			bus(1'b1, 32'h0, 3'h0, 32'h1 << b);
			tick(8);
			chk("starts", {29'h0, 3'h1 << (b - 2)}, {29'h0, seen_r});
			chk("events", (b == 2) ? 32'h0d : 32'h01, {27'h0, event_flags});
			bus(1'b1, 32'h4, 3'h0, 32'h0);
			tick(1);
			chk("events kept", (b == 2) ? 32'h0d : 32'h01, {27'h0, event_flags});
			bus(1'b1, 32'h4, 3'h0, 32'h0d);
			tick(1);
			chk("events cleared", 32'h0, {27'h0, event_flags});
		end
		make_fail <= 1'b0;
	endtask : t_commands

	task automatic t_guard();
		clr_seen();
		write_guard_on <= 1'b1;
		bus(1'b1, 32'h0, 3'h0, 32'h10);
		write_guard_on <= 1'b0;
		bus(1'b1, 32'h0, 3'h0, 32'h0);
		tick(8);
		chk("guarded start", 32'h0, {29'h0, seen_r});
	endtask : t_guard

	task automatic t_mailbox();
		bus(1'b1, 32'h41, 3'h0, 32'h0000ab00);
		tick(1);
		chk("dirty set", 32'h4, {27'h0, state_flags & 5'h0c});
		bus(1'b0, 32'h40, 3'h2, 32'h0);
		chk("mailbox byte", 32'h0000ab00, rd & 32'h0000ff00);
		tick(1);
		chk("dirty clear", 32'h0, {27'h0, state_flags & 5'h0c});
		bus(1'b1, 32'h52, 3'h1, 32'h12340000);
		tick(1);
		chk("dirty one", 32'h8, {27'h0, state_flags & 5'h0c});
		bus(1'b0, 32'h52, 3'h1, 32'h0);
		chk("mailbox half", 32'h12340000, rd & 32'hffff0000);
	endtask : t_mailbox

	task automatic t_restart();
		bus(1'b1, 32'h0, 3'h0, 32'h04);
		tick(8);
		bus(1'b1, 32'h40, 3'h2, 32'h1);
		swclk_reassigned <= 1'b1;
		tick(1);
		swclk_reassigned <= 1'b0;
		clr_seen();
		bus(1'b1, 32'h0, 3'h0, 32'h15);
		tick(8);
		chk("events restart", 32'h0, {27'h0, event_flags});
		chk("state restart", 32'h0, {27'h0, state_flags});
		chk("starts restart", 32'h0, {29'h0, seen_r});
	endtask : t_restart

	task automatic t_locked();
		rstn <= 1'b0;
		device_locked <= 1'b1;
		probe_at_coldstart <= 1'b1;
		tick(2);
		rstn <= 1'b1;
		probe_detected <= 1'b1;
		tick(3);
		probe_detected <= 1'b0;
		chk("cpu hold", 32'h1, {31'h0, cpu_hold});
		chk("state locked", 32'h13, {27'h0, state_flags});
		clr_seen();
		bus(1'b1, 32'h0, 3'h0, 32'h08);
		bus(1'b1, 32'h4, 3'h0, 32'h02);
		tick(8);
		chk("starts locked", 32'h0, {29'h0, seen_r});
		chk("lock_state_flag fault", 32'h12, {27'h0, event_flags});
		bus(1'b1, 32'h4, 3'h0, 32'h10);
		tick(1);
		chk("lock_state_flag cleared", 32'h02, {27'h0, event_flags});
	endtask : t_locked

	// ****************************************
	// sequence and watchdog
	// ****************************************
	initial begin
		// a real falling edge, so the asynchronous reset is seen
		rstn <= 1'b0;
		tick(16);
		rstn <= 1'b1;
		tick(1);
		t_reset();
		t_commands();
		t_guard();
		t_mailbox();
		t_restart();
		t_locked();
		finish_test();
	end

	initial begin
		#500000;
		miscompares++;
		finish_test();
	end
endmodule : tb

// ### verilog/debug_service_unit.sv
/*
 * command/status front end of the debug service unit, AHB-Lite slave.
 * assumes engines report done/fail/bus error as one-cycle pulses and the
 * access guard, lock and probe levels are synchronous to clk_sys.
 */
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
`include "dsu_defines.svh"

// Functional notes
// R1 - byte, halfword and word accesses are each taken whole.
// R2 - every byte and halfword of a register is addressable alone.
// R3 - writing one to command bit 4 starts chip erase.
// R4 - writing one to command bit 3 starts memory self-test.
// R5 - writing one to command bit 2 starts checksum computation.
// R6 - writing one to command bit 0 resets the unit.
// R7 - protection fault flag sets on forbidden command, one clears it.
// R8 - failure flag sets on failed operation, one clears, zero ignored.
// R9 - bus fault flag sets on bus error, one clears it.
// R10 - cold-start probe sets reset extension flag holding cpu; one clears unless locked.
// R11 - completion flag sets when an operation finishes, one clears it.
// R12 - command and status a reset zero; status b read-only, hotplug one.
// R13 - guarded registers refuse writes while the access guard is on.
// R14 - mailbox dirty flag sets on mailbox write, clears on read.
// R15 - hotplug flag clears on clock pin reassignment; only reset sets it.
// R16 - lock flag caught at power-up, probe flag on detection; never cleared.
// R17 - soft reset clears command and status flags except power-only ones.
module debug_service_unit #(
	parameter logic [31:0] MEMK_VAL = 32'h0000_0001, // arbitrary
	parameter logic [31:0] PID_VAL = 32'h0000_0000, // arbitrary
	parameter logic [31:0] CID_VAL = 32'h0000_0000 // arbitrary
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire debug_service_pkg::op_events_s op_events,
	input wire logic write_guard_on,
	input wire logic device_locked,
	input wire logic probe_at_coldstart,
	input wire logic probe_detected,
	input wire logic swclk_reassigned,
	output debug_service_pkg::op_starts_s op_starts,
	output logic cpu_hold,
	output logic [4:0] event_flags,
	output logic [4:0] state_flags
);
	debug_service_pkg::bus_state_e state_r, state_nxt;
	logic [`IDX_W-1:0] idx_r;
	logic [3:0] lanes_r, lanes_nxt;
	logic [31:0] rd_nxt;
	logic accept, wr_go, rd_go, wr_cmd, wr_eva, soft_rst, forbid_test, forbid_hold;
	logic [4:0] eva_r;
	logic hotplug_r, probe_r, lock_r, init_r;
	logic [1:0] dirty_r;
	logic [31:0] mbx_r [2];
	debug_service_pkg::op_starts_s starts_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic hresp_r;

	// ****************************************
	// bus front end
	// ****************************************
	assign accept = hsel && htrans[1] && hready;

	always_comb begin // R1 R2
		case (hsize)
			`HSIZE_BYTE: lanes_nxt = 4'h1 << haddr[1:0];
			`HSIZE_HALF: lanes_nxt = haddr[1] ? 4'hc : 4'h3;
			default: lanes_nxt = 4'hf;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			debug_service_pkg::ST_IDLE, debug_service_pkg::ST_WDATA, debug_service_pkg::ST_RDATA: begin
				if (!accept)
					state_nxt = debug_service_pkg::ST_IDLE;
				else if (hwrite)
					state_nxt = debug_service_pkg::ST_WDATA;
				else
					state_nxt = debug_service_pkg::ST_RWAIT;
			end
			debug_service_pkg::ST_RWAIT: state_nxt = debug_service_pkg::ST_RDATA;
			default: state_nxt = debug_service_pkg::ST_IDLE;
		endcase
	end

	// one wait state on reads so a read right after a write sees its effect
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= debug_service_pkg::ST_IDLE;
			idx_r <= `IDX_W'h0000;
			lanes_r <= 4'h0;
			hreadyout_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			hreadyout_r <= state_nxt != debug_service_pkg::ST_RWAIT;
			if (accept) begin
				idx_r <= haddr[`IDX_W+1:2];
				lanes_r <= lanes_nxt;
			end
		end
	end

	assign wr_go = state_r == debug_service_pkg::ST_WDATA;
	assign rd_go = state_r == debug_service_pkg::ST_RWAIT;
	assign wr_cmd = wr_go && idx_r == `IDX_CMD && lanes_r[0] && !write_guard_on; // R13
	assign wr_eva = wr_go && idx_r == `IDX_EVA && lanes_r[0] && !write_guard_on; // R13
	assign soft_rst = wr_cmd && hwdata[`CMD_RESTART]; // R6

	// ****************************************
	// command register
	// ****************************************
	// self-test and lifting the cpu hold are refused in the locked state
	assign forbid_test = wr_cmd && hwdata[`CMD_SELFTEST] && lock_r;
	assign forbid_hold = wr_eva && hwdata[`EVA_HOLD] && lock_r;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			starts_r <= '0;
		end else begin
			starts_r <= '0;
			if (wr_cmd && !soft_rst) begin
				starts_r.erase <= hwdata[`CMD_ERASE]; // R3
				starts_r.selftest <= hwdata[`CMD_SELFTEST] && !lock_r; // R4
				starts_r.checksum <= hwdata[`CMD_CHECKSUM]; // R5
			end
		end
	end

	// ****************************************
	// status a
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			eva_r <= `EVA_RESET; // R12
		end else if (soft_rst) begin
			eva_r <= `EVA_RESET; // R17
		end else begin
			// set wins over a one written in the same cycle
			eva_r[`EVA_LOCK_STATE_FLAG] <= (eva_r[`EVA_LOCK_STATE_FLAG] && !(wr_eva && hwdata[`EVA_LOCK_STATE_FLAG]))
				|| forbid_test || forbid_hold; // R7
			eva_r[`EVA_FAIL] <= (eva_r[`EVA_FAIL] && !(wr_eva && hwdata[`EVA_FAIL]))
				|| op_events.fail; // R8
			eva_r[`EVA_BUS] <= (eva_r[`EVA_BUS] && !(wr_eva && hwdata[`EVA_BUS]))
				|| op_events.bus_err; // R9
			eva_r[`EVA_HOLD] <= (eva_r[`EVA_HOLD] && !(wr_eva && hwdata[`EVA_HOLD] && !lock_r))
				|| (!init_r && probe_at_coldstart); // R10
			eva_r[`EVA_DONE] <= (eva_r[`EVA_DONE] && !(wr_eva && hwdata[`EVA_DONE]))
				|| op_events.done; // R11
		end
	end

	// ****************************************
	// status b
	// ****************************************
	// straps are caught in the first clocked cycle after release
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			init_r <= 1'b0;
			lock_r <= 1'b0;
			probe_r <= 1'b0;
			hotplug_r <= `HOTPLUG_RESET; // R12
		end else begin
			init_r <= 1'b1;
			if (!init_r)
				lock_r <= device_locked; // R16
			probe_r <= probe_r || probe_detected; // R16
			if (swclk_reassigned)
				hotplug_r <= 1'b0; // R15
		end
	end

	// ****************************************
	// mailboxes
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dirty_r <= 2'b00;
			mbx_r[0] <= 32'h0000_0000;
			mbx_r[1] <= 32'h0000_0000;
		end else begin
			for (int m = 0; m < 2; m++) begin
				if (wr_go && idx_r == (m == 0 ? `IDX_MBX0 : `IDX_MBX1)) begin
					for (int b = 0; b < 4; b++) begin
						if (lanes_r[b])
							mbx_r[m][8*b +: 8] <= hwdata[8*b +: 8];
					end
					dirty_r[m] <= 1'b1; // R14
				end else if (soft_rst) begin
					dirty_r[m] <= 1'b0; // R17
				end else if (rd_go && idx_r == (m == 0 ? `IDX_MBX0 : `IDX_MBX1)) begin
					dirty_r[m] <= 1'b0; // R14
				end
			end
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		case (idx_r)
			`IDX_EVA: rd_nxt = {27'h0, eva_r};
			`IDX_STB: rd_nxt = {27'h0, hotplug_r, dirty_r, probe_r, lock_r};
			`IDX_MBX0: rd_nxt = mbx_r[0];
			`IDX_MBX1: rd_nxt = mbx_r[1];
			`IDX_MEMK: rd_nxt = MEMK_VAL;
			`IDX_PERIPHERAL_IDENT_0, `IDX_PERIPHERAL_IDENT_1, `IDX_PERIPHERAL_IDENT_2, `IDX_PERIPHERAL_IDENT_3, `IDX_PERIPHERAL_IDENT_4: rd_nxt = PID_VAL;
			`IDX_COMPONENT_IDENT_0, `IDX_COMPONENT_IDENT_1, `IDX_COMPONENT_IDENT_2, `IDX_COMPONENT_IDENT_3: rd_nxt = CID_VAL;
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			hrdata_r <= 32'h0000_0000;
		else if (rd_go)
			hrdata_r <= rd_nxt;
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	// only okay responses; kept in a flop so every output is registered
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			hresp_r <= 1'b0;
		else
			hresp_r <= 1'b0;
	end

	assign hresp = hresp_r;
	assign op_starts = starts_r;
	assign cpu_hold = eva_r[`EVA_HOLD];
	assign event_flags = eva_r;
	assign state_flags = {hotplug_r, dirty_r, probe_r, lock_r};

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence mbx0_write;
		wr_go && idx_r == `IDX_MBX0;
	endsequence
	sequence mbx0_read;
		rd_go && idx_r == `IDX_MBX0;
	endsequence

	erase_start_a: assert property (wr_cmd && hwdata[`CMD_ERASE] && !soft_rst |=> op_starts.erase) // R3
		else $error("erase not started");
	test_start_a: assert property (op_starts.selftest |-> $past(wr_cmd) && !$past(lock_r)) // R4
		else $error("self-test started without legal write");
	crc_start_a: assert property (wr_cmd && hwdata[`CMD_CHECKSUM] && !soft_rst |=> op_starts.checksum) // R5
		else $error("checksum not started");
	soft_reset_a: assert property (soft_rst |=> event_flags == `EVA_RESET && op_starts == '0) // R6
		else $error("soft reset left flags");
	lock_state_flag_fault_a: assert property (forbid_test |=> event_flags[`EVA_LOCK_STATE_FLAG] && !op_starts.selftest) // R7
		else $error("protection fault missed");
	fail_flag_a: assert property (op_events.fail && !soft_rst |=> event_flags[`EVA_FAIL]) // R8
		else $error("failure flag missed");
	bus_flag_a: assert property (op_events.bus_err && !soft_rst |=> event_flags[`EVA_BUS]) // R9
		else $error("bus fault flag missed");
	done_flag_a: assert property (op_events.done && !soft_rst |=> event_flags[`EVA_DONE]) // R11
		else $error("done flag missed");
	guard_block_a: assert property (wr_go && write_guard_on |=> op_starts == '0) // R13
		else $error("guarded write took effect");
	mbx_dirty_a: assert property (mbx0_write |=> state_flags[2]) // R14
		else $error("mailbox dirty flag wrong");
	mbx_clear_a: assert property (mbx0_read |=> !state_flags[2]) // R14
		else $error("mailbox dirty flag not cleared");
	hotplug_a: assert property (swclk_reassigned |=> !state_flags[4] ##1 !$rose(state_flags[4])) // R15
		else $error("hotplug flag not cleared");
	read_wait_a: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout) // R1
		else $error("read not answered in two cycles");

	// ****************************************
	// further checks
	// ****************************************
	hresp_okay_a: assert property (hresp == 1'b0) // R1
		else $error("response not okay");
	write_nowait_a: assert property (accept && hwrite |=> hreadyout) // R1
		else $error("write got a wait state");
	wait_once_a: assert property (!hreadyout |=> hreadyout) // R1
		else $error("wait state longer than one cycle");
	state_onehot_a: assert property ($onehot(state_r)) // R1
		else $error("bus state not one-hot");
	read_data_a: assert property (rd_go |=> hrdata == $past(rd_nxt)) // R1
		else $error("read data not captured");
	byte_lane_a: assert property (accept && hsize == `HSIZE_BYTE |=> $onehot(lanes_r)) // R2
		else $error("byte access lanes wrong");
	half_lane_a: assert property (accept && hsize == `HSIZE_HALF |=> lanes_r == 4'h3 || lanes_r == 4'hc) // R2
		else $error("halfword access lanes wrong");
	word_lane_a: assert property (accept && hsize != `HSIZE_BYTE && hsize != `HSIZE_HALF |=> lanes_r == 4'hf) // R1
		else $error("word access lanes wrong");
	erase_off_a: assert property (!wr_cmd |=> !op_starts.erase) // R3
		else $error("erase started without write");
	erase_zero_a: assert property (wr_cmd && !hwdata[`CMD_ERASE] |=> !op_starts.erase) // R3
		else $error("zero started erase");
	test_off_a: assert property (!wr_cmd |=> !op_starts.selftest) // R4
		else $error("self-test started without write");
	test_go_a: assert property (wr_cmd && hwdata[`CMD_SELFTEST] && !lock_r && !soft_rst |=> op_starts.selftest) // R4
		else $error("self-test not started");
	crc_off_a: assert property (!wr_cmd |=> !op_starts.checksum) // R5
		else $error("checksum started without write");
	restart_dirty_a: assert property (soft_rst |=> state_flags[3:2] == 2'b00) // R17
		else $error("soft reset left mailbox flags");
	restart_lock_a: assert property (soft_rst |=> state_flags[0] == $past(state_flags[0])) // R17
		else $error("soft reset changed lock flag");
	lock_state_flag_clear_a: assert property (wr_eva && hwdata[`EVA_LOCK_STATE_FLAG] && !forbid_hold |=> !event_flags[`EVA_LOCK_STATE_FLAG]) // R7
		else $error("protection fault not cleared");
	fail_clear_a: assert property (wr_eva && hwdata[`EVA_FAIL] && !op_events.fail |=> !event_flags[`EVA_FAIL]) // R8
		else $error("failure flag not cleared");
	fail_zero_a: assert property (wr_eva && !hwdata[`EVA_FAIL] && event_flags[`EVA_FAIL] |=> event_flags[`EVA_FAIL]) // R8
		else $error("zero cleared failure flag");
	bus_clear_a: assert property (wr_eva && hwdata[`EVA_BUS] && !op_events.bus_err |=> !event_flags[`EVA_BUS]) // R9
		else $error("bus fault flag not cleared");
	done_clear_a: assert property (wr_eva && hwdata[`EVA_DONE] && !op_events.done |=> !event_flags[`EVA_DONE]) // R11
		else $error("done flag not cleared");
	hold_lift_a: assert property (wr_eva && hwdata[`EVA_HOLD] && !lock_r && init_r |=> !cpu_hold) // R10
		else $error("cpu hold not lifted");
	hold_locked_a: assert property (forbid_hold |=> cpu_hold == $past(cpu_hold) && event_flags[`EVA_LOCK_STATE_FLAG]) // R10
		else $error("locked hold lift not refused");
	guard_eva_a: assert property (wr_go && write_guard_on && idx_r == `IDX_EVA |=> $stable(event_flags[`EVA_LOCK_STATE_FLAG])) // R13
		else $error("guarded status write took effect");
	mbx1_dirty_a: assert property (wr_go && idx_r == `IDX_MBX1 |=> state_flags[3]) // R14
		else $error("second mailbox dirty flag missed");
	hotplug_stay_a: assert property (!state_flags[4] |=> !state_flags[4]) // R15
		else $error("hotplug flag set again");
	lock_stay_a: assert property (init_r |=> $stable(state_flags[0])) // R16
		else $error("lock flag changed");
	probe_set_a: assert property (probe_detected |=> state_flags[1]) // R16
		else $error("probe flag not set");
	probe_stay_a: assert property (state_flags[1] |=> state_flags[1]) // R16
		else $error("probe flag cleared");
endmodule : debug_service_unit

// ### verilog/dsu_defines.svh
/*
 * offsets, field positions and reset values of the debug service front end.
 * assumes inclusion by bare name from the design file.
 */
`ifndef DEBUG_SERVICE_DEFINES_SVH
`define DEBUG_SERVICE_DEFINES_SVH

// ****************************************
// register word indexes (byte address = index * 4)
// ****************************************
`define IDX_W 13
`define IDX_CMD 13'h0000
`define IDX_EVA 13'h0001
`define IDX_STB 13'h0002
`define IDX_MBX0 13'h0010
`define IDX_MBX1 13'h0014
`define IDX_MEMK 13'h1fcc
`define IDX_PERIPHERAL_IDENT_4 13'h1fd0
`define IDX_PERIPHERAL_IDENT_0 13'h1fe0
`define IDX_PERIPHERAL_IDENT_1 13'h1fe4
`define IDX_PERIPHERAL_IDENT_2 13'h1fe8
`define IDX_PERIPHERAL_IDENT_3 13'h1fec
`define IDX_COMPONENT_IDENT_0 13'h1ff0
`define IDX_COMPONENT_IDENT_1 13'h1ff4
`define IDX_COMPONENT_IDENT_2 13'h1ff8
`define IDX_COMPONENT_IDENT_3 13'h1ffc

// ****************************************
// field positions
// ****************************************
`define CMD_ERASE 4
`define CMD_SELFTEST 3
`define CMD_CHECKSUM 2
`define CMD_RESTART 0
`define EVA_LOCK_STATE_FLAG 4
`define EVA_FAIL 3
`define EVA_BUS 2
`define EVA_HOLD 1
`define EVA_DONE 0

// ****************************************
// reset values and bus codes
// ****************************************
`define EVA_RESET 5'h00
`define HOTPLUG_RESET 1'b1
`define HSIZE_BYTE 3'h0
`define HSIZE_HALF 3'h1
`endif

// ### verilog/dsu_pkg.sv
/*
 * types shared by the debug service front end.
 * assumes no other package.
 */
package debug_service_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WDATA = 4'h2,
		ST_RWAIT = 4'h4,
		ST_RDATA = 4'h8
	} bus_state_e;

	typedef struct packed {
		logic done;
		logic fail;
		logic bus_err;
	} op_events_s;

	typedef struct packed {
		logic erase;
		logic selftest;
		logic checksum;
	} op_starts_s;
endpackage : debug_service_pkg
